// file: logic/fast_value_regs.svh
`ifndef FAST_VALUE_REGS_SVH
`define FAST_VALUE_REGS_SVH

// Channel count and widths
`define FV_NCH        7
`define FV_VAL_W      24
`define FV_ACC_W      48

// Register indices, byte address is four times the index
`define FV_IDX_IC     8'h18
`define FV_IDX_IB     8'h19
`define FV_IDX_IA     8'h1a
`define FV_IDX_IN     8'h1b
`define FV_IDX_VA     8'h1e
`define FV_IDX_VB     8'h1f
`define FV_IDX_VC     8'h20
`define FV_IDX_CTRL   8'h8b
`define FV_IDX_WM_1ST 8'h96
`define FV_IDX_WM_2ND 8'h97
`define FV_IDX_FLAG   8'ha0
`define FV_IDX_ISTS   8'ha1
`define FV_IDX_IMASK  8'ha2

// Reset values
`define FV_CTRL_RST   24'h20ffff
`define FV_MODE_RST   24'h000000

// Field positions
`define FV_WIN_HI     23
`define FV_WIN_LO     21
`define FV_THR_HI     20
`define FV_HPF_BIT    22
`define FV_FREQ_BIT   23
`define FV_WIN_MAX    3'h5

// Arithmetic scaling
`define FV_CMP_SHIFT  3
`define FV_HPF_FRAC   8
`define FV_OUT_SHIFT  4'h6
`define FV_SAT        24'hffffff

// Half-cycle times and clock period in ns
`define FV_HALF50_NS  10000000
`define FV_HALF60_NS  8333333
`define FV_CLK_NS     10

`endif

// file: logic/fast_value_pkg.sv
`include "fast_value_regs.svh"

package fast_value_pkg;

    // Whole state of the detector
    typedef struct packed {
        logic [`FV_NCH-1:0][31:0]         dc;
        logic [`FV_NCH-1:0][`FV_ACC_W-1:0] acc;
        logic [`FV_NCH-1:0][`FV_VAL_W-1:0] val;
        logic [`FV_NCH-1:0]                over;
        logic [`FV_NCH-1:0]                ists;
        logic [`FV_NCH-1:0]                imask;
        logic [23:0]                       ctrl;
        logic [23:0]                       wm_1st;
        logic [23:0]                       wm_2nd;
        logic [19:0]                       tick;
        logic [5:0]                        halves;
        logic                              wr_pend;
        logic [7:0]                        widx;
        logic [31:0]                       rdata;
    } state_t;

endpackage

// file: logic/fast_value_detect.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

`include "fast_value_regs.svh"

module fast_value_detect
    import fast_value_pkg::*;
#(
    parameter int HALF50_CYC = `FV_HALF50_NS / `FV_CLK_NS,
    parameter int HALF60_CYC = `FV_HALF60_NS / `FV_CLK_NS
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // Sample stream, signed, one strobe for all channels
    input  wire logic        SAMPLE_VALID,
    input  wire logic [23:0] SAMPLE_IC,
    input  wire logic [23:0] SAMPLE_IB,
    input  wire logic [23:0] SAMPLE_IA,
    input  wire logic [23:0] SAMPLE_IN,
    input  wire logic [23:0] SAMPLE_VA,
    input  wire logic [23:0] SAMPLE_VB,
    input  wire logic [23:0] SAMPLE_VC,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    // Detector outputs
    output logic [6:0]       OVER_FLAG,
    output logic             IRQ
);

    state_t                              r;
    state_t                              n;

    logic [`FV_NCH-1:0][23:0]            smp;
    logic [`FV_NCH-1:0][24:0]            mag;
    logic [`FV_NCH-1:0][31:0]            dc_next;
    logic [`FV_NCH-1:0][`FV_VAL_W-1:0]   res;
    logic [`FV_NCH-1:0]                  res_over;

    logic [2:0]                          win;
    logic [3:0]                          shamt;
    logic [19:0]                         half_len;
    logic [5:0]                          half_num;
    logic [20:0]                         thr;
    logic                                hpf_on;
    logic                                take;
    logic                                win_end;
    logic [`FV_NCH-1:0]                  rise;

    // Channel order follows register order, IC first
    assign smp = {SAMPLE_VC, SAMPLE_VB, SAMPLE_VA, SAMPLE_IN,
                  SAMPLE_IA, SAMPLE_IB, SAMPLE_IC};

    // Window code, undefined codes clamp to the longest window
    assign win = (r.ctrl[`FV_WIN_HI:`FV_WIN_LO] > `FV_WIN_MAX) ?
                 `FV_WIN_MAX : r.ctrl[`FV_WIN_HI:`FV_WIN_LO];

    // Window length counted in half cycles of the grid
    assign half_num = 6'h01 << win;

    // Half-cycle length from the grid frequency bit
    assign half_len = r.wm_2nd[`FV_FREQ_BIT] ?
                      20'(HALF60_CYC) : 20'(HALF50_CYC);

    // Output scaling keeps the sum in 24 bits per window length
    assign shamt = `FV_OUT_SHIFT + {1'b0, win};

    // Shared threshold field
    assign thr = r.ctrl[`FV_THR_HI:0];

    // Filter routing bit
    assign hpf_on = r.wm_1st[`FV_HPF_BIT];

    // Per-channel filter, rectifier and result scaling
    for (genvar i = 0; i < `FV_NCH; i++) begin : g_ch
        logic signed [24:0]         raw;
        logic signed [24:0]         hp;
        logic signed [24:0]         sel;
        logic [`FV_ACC_W-1:0]       shv;

        // Sign-extended sample
        assign raw = {smp[i][23], smp[i]};

        // DC estimate removed from the sample
        assign hp = raw - {r.dc[i][31], r.dc[i][31:`FV_HPF_FRAC]};

        // DC tracker integrates the filtered output
        assign dc_next[i] = r.dc[i] + {{7{hp[24]}}, hp};

        // Filtered or raw waveform
        assign sel = hpf_on ? hp : raw;

        // Absolute value
        assign mag[i] = sel[24] ? 25'(-sel) : 25'(sel);

        // Scaled sum, saturated to 24 bits
        assign shv = r.acc[i] >> shamt;
        assign res[i] = (|shv[`FV_ACC_W-1:`FV_VAL_W]) ? `FV_SAT :
                        shv[`FV_VAL_W-1:0];

        // Value over eight against the threshold
        assign res_over[i] = res[i][23:`FV_CMP_SHIFT] > thr;
    end

    // Address phase taken on the bus
    assign take = HSEL & HTRANS[1] & HREADY;

    // Register read multiplexer
    function automatic logic [31:0] rd(input logic [7:0] idx, input state_t s);
        logic [31:0] d;
        d = '0;
        unique case (idx)
            `FV_IDX_IC:    d = {8'h00, s.val[0]};
            `FV_IDX_IB:    d = {8'h00, s.val[1]};
            `FV_IDX_IA:    d = {8'h00, s.val[2]};
            `FV_IDX_IN:    d = {8'h00, s.val[3]};
            `FV_IDX_VA:    d = {8'h00, s.val[4]};
            `FV_IDX_VB:    d = {8'h00, s.val[5]};
            `FV_IDX_VC:    d = {8'h00, s.val[6]};
            `FV_IDX_CTRL:  d = {8'h00, s.ctrl};
            `FV_IDX_WM_1ST: d = {8'h00, s.wm_1st};
            `FV_IDX_WM_2ND: d = {8'h00, s.wm_2nd};
            `FV_IDX_FLAG:  d = {25'h0000000, s.over};
            `FV_IDX_ISTS:  d = {25'h0000000, s.ists};
            `FV_IDX_IMASK: d = {25'h0000000, s.imask};
            default:       d = '0;
        endcase
        return d;
    endfunction

    // Next-state logic
    always_comb begin
        n       = r;
        win_end = 1'b0;
        rise    = '0;

        // Sum rectified samples and track DC
        if (SAMPLE_VALID) begin
            for (int i = 0; i < `FV_NCH; i++) begin
                n.acc[i] = r.acc[i] + `FV_ACC_W'(mag[i]);
                n.dc[i]  = dc_next[i];
            end
        end

        // Half-cycle timer and window end
        if (r.tick >= half_len - 20'h00001) begin
            n.tick = '0;
            if (r.halves >= half_num - 6'h01) begin
                n.halves = '0;
                win_end  = 1'b1;
            end else begin
                n.halves = r.halves + 6'h01;
            end
        end else begin
            n.tick = r.tick + 20'h00001;
        end

        // Load results, refresh flags, restart sums
        if (win_end) begin
            for (int i = 0; i < `FV_NCH; i++) begin
                n.val[i]  = res[i];
                n.over[i] = res_over[i];
                n.acc[i]  = SAMPLE_VALID ? `FV_ACC_W'(mag[i]) : '0;
            end
        end

        // Newly raised flags
        rise = n.over & ~r.over;

        // Data phase of a write
        if (r.wr_pend) begin
            unique case (r.widx)
                `FV_IDX_CTRL:  n.ctrl  = HWDATA[23:0];
                `FV_IDX_WM_1ST: n.wm_1st = HWDATA[23:0];
                `FV_IDX_WM_2ND: n.wm_2nd = HWDATA[23:0];
                `FV_IDX_ISTS:  n.ists  = r.ists & ~HWDATA[6:0];
                `FV_IDX_IMASK: n.imask = HWDATA[6:0];
                default:       n.ctrl  = r.ctrl;
            endcase
        end

        // Sticky status, a set beats a clear
        n.ists = n.ists | rise;

        // Address phase capture and read data
        n.wr_pend = take & HWRITE;
        if (take) begin
            n.widx = HADDR[9:2];
            if (!HWRITE) begin
                n.rdata = rd(HADDR[9:2], r);
            end
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            r       <= '0;
            r.ctrl  <= `FV_CTRL_RST;
            r.wm_1st <= `FV_MODE_RST;
            r.wm_2nd <= `FV_MODE_RST;
        end else begin
            r <= n;
        end
    end

    // Bus answers: no wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = r.rdata;

    // Detector outputs
    assign OVER_FLAG = r.over;
    assign IRQ       = |(r.ists & r.imask);

endmodule // fast_value_detect

// file: tb/fast_value_checker.sv
`timescale 1ns/1ps
module fast_value_checker #(parameter int HALF60_CYC = 83) (
    // Watched ports
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        SAMPLE_VALID,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [6:0]  OVER_FLAG,
    input wire logic        IRQ
);
    logic [6:0] flag_r;
    int         gap_r;
    logic       seen_r;
    wire        chg = OVER_FLAG != flag_r;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // Flag history, cycles since last change, stream seen
    always_ff @(posedge SYS_CLK) begin
        flag_r <= RESET ? 7'h00 : OVER_FLAG;
        gap_r  <= (RESET || chg) ? 0 : gap_r + 1;
        seen_r <= !RESET && (seen_r || SAMPLE_VALID);
    end
    property p_ready; HREADYOUT; endproperty
    a_ready: assert property (p_ready) else $error("wait state");
    property p_okay; !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rd_hold; !(HSEL && HTRANS[1] && !HWRITE && HREADY) |=> $stable(HRDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_hi_zero; HRDATA[31:24] == 8'h00; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_flag_gap; chg |-> gap_r >= HALF60_CYC / 2; endproperty
    a_flag_gap: assert property (p_flag_gap) else $error("flag changed mid window");
    property p_flag_hold; chg |=> $stable(OVER_FLAG) [*8]; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag not held");
    property p_flag_src; OVER_FLAG != 7'h00 |-> seen_r; endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag without samples");
    property p_irq_src; IRQ |-> seen_r; endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without samples");
    // Main scenarios reached
    c_flag: cover property (chg && OVER_FLAG != 7'h00);
    c_irq: cover property ($rose(IRQ));
    c_read: cover property (HSEL && HTRANS[1] && !HWRITE);
endmodule // fast_value_checker

bind fast_value_detect fast_value_checker #(.HALF60_CYC(HALF60_CYC)) chk_u (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .OVER_FLAG(OVER_FLAG), .IRQ(IRQ));

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "fast_value_regs.svh"
module testbench;
    // Stimulus and observed signals
    logic        SYS_CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        SAMPLE_VALID = 1'b0;
    logic        HSEL = 1'b0;
    logic        HWRITE = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] rd;
    logic [23:0] smp [7] = '{default: 24'h0};
    wire         HREADYOUT, HRESP, IRQ;
    wire  [31:0] HRDATA;
    wire  [6:0]  OVER_FLAG;
    int          miscompares = 0, cmp_count = 0, base = 0, tnow = 0;
    bit          feed, alt, ramp, tg;
    localparam logic [7:0] IDX [7] = '{`FV_IDX_IC, `FV_IDX_IB, `FV_IDX_IA, `FV_IDX_IN,
                                       `FV_IDX_VA, `FV_IDX_VB, `FV_IDX_VC};

    always #5 SYS_CLK = ~SYS_CLK;

    // Sample source, channel n carries (n+1)*base
    always @(posedge SYS_CLK) begin
        tnow <= tnow + 1;
        tg <= ~tg;
        SAMPLE_VALID <= feed;
        if (ramp) base <= base + 1;
        for (int i = 0; i < 7; i++) smp[i] <= 24'((alt && tg) ? -base * (i + 1) : base * (i + 1));
    end

    fast_value_detect #(.HALF50_CYC(100), .HALF60_CYC(83)) dut_u (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_IC(smp[0]), .SAMPLE_IB(smp[1]), .SAMPLE_IA(smp[2]), .SAMPLE_IN(smp[3]),
        .SAMPLE_VA(smp[4]), .SAMPLE_VB(smp[5]), .SAMPLE_VC(smp[6]),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .OVER_FLAG(OVER_FLAG), .IRQ(IRQ));

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One AHB-Lite single word transfer
    task bus(input logic [7:0] i, input logic w, input logic [31:0] d);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {22'h0, i, 2'h0};
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task rchk(input string n, input logic [7:0] i, input logic [31:0] e);
        bus(i, 1'b0, 32'h0);
        chk(n, e, rd);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    // Time between two result updates under a ramp
    task win(input int w);
        int t0;
        logic [31:0] v;
        cyc(2 * w);
        bus(`FV_IDX_IA, 1'b0, 32'h0);
        v = rd;
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 9000 && rd === v; n++) bus(`FV_IDX_IA, 1'b0, 32'h0);
            v = rd;
            if (k == 0) t0 = tnow;
        end
        chk("window", 32'(w), ((tnow - t0 - w) inside {[-2:2]}) ? 32'(w) : 32'(tnow - t0));
    endtask

    task t_reset;
        for (int i = 0; i < 7; i++) rchk("value", IDX[i], 32'h0);
        rchk("ctrl", `FV_IDX_CTRL, 32'h20ffff);
        rchk("wm_1st", `FV_IDX_WM_1ST, 32'h0);
        rchk("wm_2nd", `FV_IDX_WM_2ND, 32'h0);
        bus(`FV_IDX_IA, 1'b1, 32'hffffff);
        rchk("readonly", `FV_IDX_IA, 32'h0);
        rchk("unmapped", 8'h50, 32'h0);
        $display("reset test done");
    endtask
    task t_flags;
        base = 4096;
        feed = 1;
        alt = 1;
        bus(`FV_IDX_CTRL, 1'b1, 32'h960);
        cyc(300);
        for (int i = 0; i < 7; i++) rchk("value", IDX[i], 32'(6400 * (i + 1)));
        chk("flags", 32'h78, {25'h0, OVER_FLAG});
        rchk("flagreg", `FV_IDX_FLAG, 32'h78);
        rchk("status", `FV_IDX_ISTS, 32'h78);
        chk("irq", 32'h0, {31'h0, IRQ});
        bus(`FV_IDX_IMASK, 1'b1, 32'h7f);
        rchk("mask", `FV_IDX_IMASK, 32'h7f);
        chk("irq", 32'h1, {31'h0, IRQ});
        bus(`FV_IDX_ISTS, 1'b1, 32'h7f);
        rchk("cleared", `FV_IDX_ISTS, 32'h0);
        chk("irq", 32'h0, {31'h0, IRQ});
        bus(`FV_IDX_CTRL, 1'b1, 32'h1fffff);
        cyc(250);
        chk("flags", 32'h0, {25'h0, OVER_FLAG});
        $display("flag test done");
    endtask
    task t_codes;
        ramp = 1;
        for (int c = 0; c < 6; c++) begin
            bus(`FV_IDX_CTRL, 1'b1, {8'h0, 3'(c), 21'h1fffff});
            win(100 << c);
        end
        // Undefined code falls back to the longest window
        bus(`FV_IDX_CTRL, 1'b1, {8'h0, 3'h7, 21'h1fffff});
        win(3200);
        bus(`FV_IDX_CTRL, 1'b1, 32'h1fffff);
        bus(`FV_IDX_WM_2ND, 1'b1, 32'h800000);
        win(83);
        bus(`FV_IDX_WM_2ND, 1'b1, 32'h0);
        ramp = 0;
        $display("window test done");
    endtask
    task t_hpf;
        alt = 0;
        base = 4096;
        cyc(300);
        rchk("bypass", `FV_IDX_IA, 32'h4b00);
        bus(`FV_IDX_WM_1ST, 1'b1, 32'h400000);
        cyc(3000);
        bus(`FV_IDX_IA, 1'b0, 32'h0);
        chk("highpass", 32'h1, {31'h0, rd < 32'h780});
        $display("filter test done");
    endtask

    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESET <= 1'b0;
        t_reset;
        t_flags;
        t_codes;
        t_hpf;
        stop_test;
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge SYS_CLK);
        miscompares++;
        stop_test;
    end
endmodule // testbench
